// File: rtl/acr_pkg.sv
// constants for the adc channel result and scan back end
// assumes a 32-bit apb slave, one aligned word per register
// How it works
// - two-bit priority field enables the channel interrupt and sets its level
// - flag sets on conversion done, or on compare condition in compare mode
// - flag clears when the controller dispatches the channel vector
// - writing one to flag bit clears it; zero leaves it
// - signed values are two's complement with msb as sign
// - low and high bytes form one 16-bit channel value
// - left adjusted: bits 11:4 in high byte, 3:0 in low byte upper nibble
// - right adjusted: bits 11:8 in high byte lower nibble
// - right adjusted: high upper nibble is sign copy when signed, else zero
// - 8-bit: high byte is bit seven copy when signed, else zero
// - right adjusted and 8-bit: bits 7:0 in low byte
// - scanning is on whenever count is nonzero
// - scan register and sequencing exist only for channel 0
// - effective positive select is base selection plus offset
// - offset increments per scanned conversion, wraps to zero at count
// - a scan covers count plus one inputs from base to base plus count
// - condition select: 00 complete, 01 below, 11 above, 10 reserved
package acr_pkg;
    // register index; one aligned word each, so byte address is four times it
    localparam int          IDX_CTRL     = 0;
    localparam int          IDX_MUX      = 1;
    localparam int          IDX_INTCTRL  = 2;
    localparam int          IDX_FLAG     = 3;
    localparam int          IDX_LOW      = 4;
    localparam int          IDX_HIGH     = 5;
    localparam int          IDX_SCAN     = 6;
    localparam int          IDX_CMP      = 7;
    localparam int          IDX_WORD     = 8;
    localparam logic [7:0]  OFS_CTRL     = 8'(IDX_CTRL * 4);
    localparam logic [7:0]  OFS_MUX      = 8'(IDX_MUX * 4);
    localparam logic [7:0]  OFS_INTCTRL  = 8'(IDX_INTCTRL * 4);
    localparam logic [7:0]  OFS_FLAG     = 8'(IDX_FLAG * 4);
    localparam logic [7:0]  OFS_LOW      = 8'(IDX_LOW * 4);
    localparam logic [7:0]  OFS_HIGH     = 8'(IDX_HIGH * 4);
    localparam logic [7:0]  OFS_SCAN     = 8'(IDX_SCAN * 4);
    localparam logic [7:0]  OFS_CMP      = 8'(IDX_CMP * 4);
    localparam logic [7:0]  OFS_WORD     = 8'(IDX_WORD * 4);
    localparam int          CTRL_SIGNED  = 0;
    localparam int          CTRL_RES_LO  = 1;
    localparam int          MUX_POS_LO   = 3;
    localparam int          LVL_LO       = 0;
    localparam int          MODE_LO      = 2;
    localparam int          SCAN_OFS_LO  = 4;
    localparam logic [7:0]  RST_BYTE     = 8'h00;
    localparam logic [15:0] RST_CMP      = 16'h0000;
    typedef enum logic [1:0] {
        ACR_RES_12R, ACR_RES_8, ACR_RES_12L, ACR_RES_RSVD
    } acr_res_t;
    typedef enum logic [1:0] {
        ACR_IM_DONE, ACR_IM_BELOW, ACR_IM_RSVD, ACR_IM_ABOVE
    } acr_im_t;
endpackage

// File: rtl/acr_format.sv
// result formatter: raw conversion value to low/high byte pair
// assumes a stable raw value and mode inputs
module acr_format (
    input  wire logic [11:0] raw,
    input  wire logic        is_signed,
    input  wire logic [1:0]  res_sel,
    output logic      [7:0]  value_low_byte,
    output logic      [7:0]  value_high_byte
);
    always_comb begin
        case (acr_pkg::acr_res_t'(res_sel))
            acr_pkg::ACR_RES_12L: begin
                value_high_byte = raw[11:4];
                value_low_byte  = {raw[3:0], 4'h0};
            end
            acr_pkg::ACR_RES_8: begin
                value_high_byte = is_signed ? {8{raw[7]}} : 8'h00;
                value_low_byte  = raw[7:0];
            end
            default: begin
                value_high_byte = {(is_signed ? {4{raw[11]}} : 4'h0),
                                   raw[11:8]};
                value_low_byte  = raw[7:0];
            end
        endcase
    end
endmodule

// File: rtl/acr_channel.sv
// one adc channel back end: flag, irq level, result bytes, input scan
// assumes an apb master and a converter that pulses conv_done with conv_value
//
// The APB slave port was left to the implementer.
module acr_channel #(
    parameter bit HAS_SCAN = 1'b1
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done,
    input  wire logic [11:0] conv_value,
    input  wire logic        vector_ack,
    output logic      [1:0]  irq_priority_level,
    output logic             irq_req,
    output logic      [3:0]  positive_input_select
);
    logic [7:0]  ctrl;
    logic [7:0]  mux;
    logic [7:0]  intctrl;
    logic        flag;
    logic [7:0]  scan;
    logic [15:0] cmp;
    logic [11:0] raw;
    logic [7:0]  high_hold;
    logic [7:0]  fmt_low;
    logic [7:0]  fmt_high;
    logic [15:0] conversion_word;
    logic        set_cond;
    logic        clr_cond;
    logic        wr_acc;
    logic        rd_acc;
    logic        addr_ok;
    logic [3:0]  next_offset;
    logic [3:0]  scan_count;
    logic [3:0]  scan_offset;
    logic signed [15:0] fresh_word;

    acr_format u_fmt (
        .raw             (conv_value),
        .is_signed       (ctrl[acr_pkg::CTRL_SIGNED]),
        .res_sel         (ctrl[acr_pkg::CTRL_RES_LO +: 2]),
        .value_low_byte  (fmt_low),
        .value_high_byte (fmt_high)
    );

    acr_format u_fmt_held (
        .raw             (raw),
        .is_signed       (ctrl[acr_pkg::CTRL_SIGNED]),
        .res_sel         (ctrl[acr_pkg::CTRL_RES_LO +: 2]),
        .value_low_byte  (conversion_word[7:0]),
        .value_high_byte (conversion_word[15:8])
    );

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == acr_pkg::OFS_CTRL) || (a == acr_pkg::OFS_MUX)
              || (a == acr_pkg::OFS_INTCTRL) || (a == acr_pkg::OFS_FLAG)
              || (a == acr_pkg::OFS_LOW) || (a == acr_pkg::OFS_HIGH)
              || (a == acr_pkg::OFS_SCAN) || (a == acr_pkg::OFS_CMP)
              || (a == acr_pkg::OFS_WORD);
    endfunction

    assign addr_ok     = mapped(paddr);
    assign wr_acc      = clk_en && psel && penable && pready && pwrite && addr_ok && pstrb[0];
    assign rd_acc      = clk_en && psel && penable && pready && !pwrite && addr_ok;
    assign scan_count  = HAS_SCAN ? scan[3:0] : 4'h0;
    assign scan_offset = scan[acr_pkg::SCAN_OFS_LO +: 4];
    assign fresh_word  = {fmt_high, fmt_low};

    // compare works on the formatted 16-bit word, signed when converting signed
    always_comb begin
        logic below;
        logic above;
        below = ctrl[acr_pkg::CTRL_SIGNED] ? (fresh_word < $signed(cmp))
                                           : ({fmt_high, fmt_low} < cmp);
        above = ctrl[acr_pkg::CTRL_SIGNED] ? (fresh_word > $signed(cmp))
                                           : ({fmt_high, fmt_low} > cmp);
        case (acr_pkg::acr_im_t'(intctrl[acr_pkg::MODE_LO +: 2]))
            acr_pkg::ACR_IM_DONE:  set_cond = conv_done;
            acr_pkg::ACR_IM_BELOW: set_cond = conv_done && below;
            acr_pkg::ACR_IM_ABOVE: set_cond = conv_done && above;
            default:               set_cond = 1'b0;
        endcase
    end

    assign clr_cond = vector_ack
                   || (wr_acc && paddr == acr_pkg::OFS_FLAG && pwdata[0]);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag <= 1'b0;
        end else if (clk_en) begin
            if (set_cond) begin
                flag <= 1'b1;
            end else if (clr_cond) begin
                flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_req            <= 1'b0;
            irq_priority_level <= 2'b00;
        end else if (clk_en) begin
            irq_priority_level <= intctrl[acr_pkg::LVL_LO +: 2];
            irq_req <= (intctrl[acr_pkg::LVL_LO +: 2] != 2'b00)
                    && (set_cond || (flag && !clr_cond));
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl    <= acr_pkg::RST_BYTE;
            mux     <= acr_pkg::RST_BYTE;
            intctrl <= acr_pkg::RST_BYTE;
            cmp     <= acr_pkg::RST_CMP;
        end else if (wr_acc) begin
            if (paddr == acr_pkg::OFS_CTRL) begin
                ctrl <= {5'h00, pwdata[2:0]};
            end else if (paddr == acr_pkg::OFS_MUX) begin
                mux <= {1'b0, pwdata[6:0]};
            end else if (paddr == acr_pkg::OFS_INTCTRL) begin
                intctrl <= {4'h0, pwdata[3:0]};
            end else if (paddr == acr_pkg::OFS_CMP) begin
                cmp <= pstrb[1] ? pwdata[15:0] : {cmp[15:8], pwdata[7:0]};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            raw <= 12'h000;
        end else if (clk_en && conv_done) begin
            raw <= conv_value;
        end
    end

    always_comb begin
        if (scan_offset == scan_count) begin
            next_offset = 4'h0;
        end else begin
            next_offset = scan_offset + 4'h1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scan <= acr_pkg::RST_BYTE;
        end else if (clk_en && HAS_SCAN) begin
            if (wr_acc && paddr == acr_pkg::OFS_SCAN) begin
                scan <= pwdata[7:0];
            end else if (conv_done && scan_count != 4'h0) begin
                scan[acr_pkg::SCAN_OFS_LO +: 4] <= next_offset;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            positive_input_select <= 4'h0;
        end else if (clk_en) begin
            if (scan_count != 4'h0) begin
                positive_input_select <= 4'(mux[acr_pkg::MUX_POS_LO +: 4] + scan_offset);
            end else begin
                positive_input_select <= mux[acr_pkg::MUX_POS_LO +: 4];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            high_hold <= acr_pkg::RST_BYTE;
        end else if (rd_acc && paddr == acr_pkg::OFS_LOW) begin
            high_hold <= conversion_word[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                if (paddr == acr_pkg::OFS_CTRL) begin
                    prdata <= {24'h000000, ctrl};
                end else if (paddr == acr_pkg::OFS_MUX) begin
                    prdata <= {24'h000000, mux};
                end else if (paddr == acr_pkg::OFS_INTCTRL) begin
                    prdata <= {24'h000000, intctrl};
                end else if (paddr == acr_pkg::OFS_FLAG) begin
                    prdata <= {31'h0000_0000, flag};
                end else if (paddr == acr_pkg::OFS_LOW) begin
                    prdata <= {24'h000000, conversion_word[7:0]};
                end else if (paddr == acr_pkg::OFS_HIGH) begin
                    prdata <= {24'h000000, high_hold};
                end else if (paddr == acr_pkg::OFS_SCAN) begin
                    prdata <= HAS_SCAN ? {24'h000000, scan} : 32'h0000_0000;
                end else if (paddr == acr_pkg::OFS_CMP) begin
                    prdata <= {16'h0000, cmp};
                end else if (paddr == acr_pkg::OFS_WORD) begin
                    prdata <= {16'h0000, conversion_word};
                end
            end
        end
    end

    set_wins_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && set_cond |=> flag)
        else $error("flag lost a set");
    ack_clears_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && vector_ack && !set_cond |=> !flag)
        else $error("dispatch did not clear flag");
    w1c_zero_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_acc && paddr == acr_pkg::OFS_FLAG && !pwdata[0] && !vector_ack && flag
        |=> flag)
        else $error("zero write cleared flag");
    irq_follow_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && flag && intctrl[1:0] == 2'b00 |=> !irq_req)
        else $error("irq raised while disabled");
    scan_step_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && scan_count != 4'h0 && !wr_acc && scan_offset == scan_count
        |=> scan_offset == 4'h0)
        else $error("offset failed to wrap");
    scan_sel_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && scan_count != 4'h0 |=>
        positive_input_select == 4'($past(mux[6:3]) + $past(scan_offset)))
        else $error("wrong scanned select");
    left_fmt_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b10 |-> conversion_word[3:0] == 4'h0
        && conversion_word[15:8] == raw[11:4])
        else $error("left adjust layout wrong");
    sign_ext_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b01 && !ctrl[0] |-> conversion_word[15:8] == 8'h00)
        else $error("unsigned 8-bit high byte not zero");
    flag_rd_a: assert property (@(posedge core_clk) disable iff (rst)
        pready && !pwrite && paddr == acr_pkg::OFS_FLAG |-> prdata[31:1] == 31'h0)
        else $error("reserved flag bits nonzero");

    // flag and request against their conditions
    w1c_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && wr_acc && paddr == acr_pkg::OFS_FLAG && pwdata[0] && !set_cond |=> !flag)
        else $error("one write left flag set");
    flag_hold_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && flag && !clr_cond |=> flag)
        else $error("flag dropped without a clear");
    flag_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !flag && !set_cond |=> !flag)
        else $error("flag set without a condition");
    irq_on_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && set_cond && intctrl[1:0] != 2'b00 |=> irq_req)
        else $error("enabled set raised no request");
    irq_off_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !flag && !set_cond |=> !irq_req)
        else $error("request without a flag");
    level_copy_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en |=> irq_priority_level == $past(intctrl[1:0]))
        else $error("priority level not forwarded");

    // compare modes, unsigned layouts
    mode_rsvd_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && intctrl[3:2] == 2'b10 && !flag |=> !flag)
        else $error("reserved mode set the flag");
    below_set_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && intctrl[3:2] == 2'b01 && !ctrl[0]
        && {fmt_high, fmt_low} < cmp |=> flag)
        else $error("below condition missed");
    below_none_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && intctrl[3:2] == 2'b01 && !ctrl[0] && !flag
        && {fmt_high, fmt_low} >= cmp |=> !flag)
        else $error("below mode set on a high value");
    above_set_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && intctrl[3:2] == 2'b11 && !ctrl[0]
        && {fmt_high, fmt_low} > cmp |=> flag)
        else $error("above condition missed");
    above_none_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && intctrl[3:2] == 2'b11 && !ctrl[0] && !flag
        && {fmt_high, fmt_low} <= cmp |=> !flag)
        else $error("above mode set on a low value");

    // result layout and byte pairing
    left_low_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b10 |-> conversion_word[7:4] == raw[3:0])
        else $error("left adjust low nibble wrong");
    right_fmt_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b00 |-> conversion_word[11:0] == raw
        && conversion_word[15:12] == (ctrl[0] ? {4{raw[11]}} : 4'h0))
        else $error("right adjust layout wrong");
    eight_fmt_a: assert property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b01 |-> conversion_word[7:0] == raw[7:0]
        && (!ctrl[0] || conversion_word[15:8] == {8{raw[7]}}))
        else $error("8-bit layout wrong");
    high_latch_a: assert property (@(posedge core_clk) disable iff (rst)
        rd_acc && paddr == acr_pkg::OFS_LOW |=> high_hold == $past(conversion_word[15:8]))
        else $error("high byte not latched");
    high_rd_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && psel && !penable && !pwrite && paddr == acr_pkg::OFS_HIGH
        |=> prdata == {24'h000000, $past(high_hold)})
        else $error("high read not from latch");
    word_rd_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && psel && !penable && !pwrite && paddr == acr_pkg::OFS_WORD
        |=> prdata == {16'h0000, $past(conversion_word)})
        else $error("word read wrong");
    pready_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && pready |=> !pready)
        else $error("ready stood too long");

    // scan sequencing
    scan_inc_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && conv_done && scan_count != 4'h0 && scan_offset != scan_count
        && !(wr_acc && paddr == acr_pkg::OFS_SCAN)
        |=> scan_offset == 4'($past(scan_offset) + 4'h1))
        else $error("offset failed to step");
    scan_keep_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && !conv_done && !(wr_acc && paddr == acr_pkg::OFS_SCAN)
        |=> scan_offset == $past(scan_offset))
        else $error("offset moved without a conversion");
    no_scan_a: assert property (@(posedge core_clk) disable iff (rst)
        clk_en && scan_count == 4'h0 |=> positive_input_select == $past(mux[6:3]))
        else $error("select moved with scan off");

    done_cov_c: cover property (@(posedge core_clk) disable iff (rst) set_cond ##1 flag);
    ack_cov_c: cover property (@(posedge core_clk) disable iff (rst) flag && vector_ack);
    wrap_cov_c: cover property (@(posedge core_clk) disable iff (rst)
        conv_done && scan_count != 4'h0 && scan_offset == scan_count);
    left_cov_c: cover property (@(posedge core_clk) disable iff (rst)
        ctrl[2:1] == 2'b10 && conv_done);
    clear_cov_c: cover property (@(posedge core_clk) disable iff (rst)
        wr_acc && paddr == acr_pkg::OFS_FLAG && pwdata[0] && flag);
endmodule

// File: testbench/acr_irq_model.sv
// interrupt controller stand-in: dispatches the channel vector
// assumes irq_req is a level held until the flag is cleared
module acr_irq_model (
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ack_en,
    input  wire logic [3:0] lat,
    input  wire logic       irq_req,
    input  wire logic [1:0] irq_priority_level,
    output logic            vector_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt;
    // one-cycle dispatch after lat waiting cycles, enabled levels only
    always_ff @(posedge core_clk) begin
        vector_ack <= 1'b0;
        if (rst || !ack_en || !irq_req || vector_ack) begin
            cnt <= 4'h0;
        end else if (irq_priority_level != 2'h0) begin
            if (cnt == lat) begin
                vector_ack <= 1'b1;
            end
            cnt <= cnt + 4'h1;
        end
    end
endmodule

// File: testbench/acr_channel_tb.sv
// self-checking bench for one adc channel back end
// assumes zero-wait apb answers and a registered flag and mux select
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module acr_channel_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        conv_done, vector_ack, irq_req, ack_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] conv_value;
    logic [1:0]  irq_priority_level;
    logic [3:0]  positive_input_select, lat;
    int          mismatches = 0;
    int          n_checks = 0;

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    acr_channel #(.HAS_SCAN(1'b1)) uut (
        .core_clk              (core_clk),
        .rst                   (rst),
        .clk_en                (1'b1),
        .psel                  (psel),
        .penable               (penable),
        .pwrite                (pwrite),
        .paddr                 (paddr),
        .pwdata                (pwdata),
        .pstrb                 (4'hF),
        .prdata                (prdata),
        .pready                (pready),
        .pslverr               (pslverr),
        .conv_done             (conv_done),
        .conv_value            (conv_value),
        .vector_ack            (vector_ack),
        .irq_priority_level    (irq_priority_level),
        .irq_req               (irq_req),
        .positive_input_select (positive_input_select)
    );

    acr_irq_model irq_ctl (
        .core_clk           (core_clk),
        .rst                (rst),
        .ack_en             (ack_en),
        .lat                (lat),
        .irq_req            (irq_req),
        .irq_priority_level (irq_priority_level),
        .vector_ack         (vector_ack)
    );

    task automatic end_sim();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            end_sim();
        end
        @(posedge core_clk);
    endtask

    task automatic conv(input logic [11:0] v);
        conv_done <= 1'b1;
        conv_value <= v;
        @(posedge core_clk);
        conv_done <= 1'b0;
        @(posedge core_clk);
    endtask

    // expected byte pair for a raw value in each layout
    function automatic logic [15:0] fmt(logic [11:0] v, logic s, int r);
        case (r)
            0: return {(s ? {4{v[11]}} : 4'h0), v};
            1: return {(s ? {8{v[7]}} : 8'h0), v[7:0]};
            default: return {v, 4'h0};
        endcase
    endfunction

    task automatic t_reset();
        apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
        `CHK("flag reset", 32'h0, rd)
        apb(1'b0, acr_pkg::OFS_SCAN, 32'h0);
        `CHK("scan reset", 32'h0, rd)
        apb(1'b0, 8'hFC, 32'h0);
        `CHK("unmapped err", 1'b1, err)
    endtask

    task automatic t_flag();
        apb(1'b1, acr_pkg::OFS_INTCTRL, 32'h0);
        conv(12'h123);
        apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
        `CHK("flag set", 32'h1, rd)
        `CHK("irq masked", 1'b0, irq_req)
        apb(1'b1, acr_pkg::OFS_FLAG, 32'h0);
        apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
        `CHK("flag kept", 32'h1, rd)
        apb(1'b1, acr_pkg::OFS_FLAG, 32'h1);
        apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
        `CHK("flag cleared", 32'h0, rd)
    endtask

    task automatic t_format();
        logic [11:0] v [2] = '{12'hA5C, 12'h39B};
        logic [15:0] e;
        for (int r = 0; r < 3; r++) begin
            for (int k = 0; k < 4; k++) begin
                apb(1'b1, acr_pkg::OFS_CTRL, {29'h0, 2'(r), k[1]});
                conv(v[k%2]);
                e = fmt(v[k%2], k[1], r);
                apb(1'b0, acr_pkg::OFS_LOW, 32'h0);
                `CHK("low byte", {24'h0, e[7:0]}, rd)
                conv(v[1-k%2]);
                apb(1'b0, acr_pkg::OFS_HIGH, 32'h0);
                `CHK("latched high", {24'h0, e[15:8]}, rd)
                apb(1'b0, acr_pkg::OFS_WORD, 32'h0);
                `CHK("word", {16'h0, fmt(v[1-k%2], k[1], r)}, rd)
            end
        end
    endtask

    task automatic t_compare();
        logic [3:0]  m [6] = '{4'h4, 4'h4, 4'h8, 4'h8, 4'hC, 4'hC};
        logic [11:0] v [6] = '{12'h050, 12'h200, 12'h050, 12'h200, 12'h200, 12'h050};
        logic        e [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
        apb(1'b1, acr_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, acr_pkg::OFS_CMP, 32'h100);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, acr_pkg::OFS_INTCTRL, {28'h0, m[i]});
            apb(1'b1, acr_pkg::OFS_FLAG, 32'h1);
            conv(v[i]);
            apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
            `CHK("compare flag", {31'h0, e[i]}, rd)
        end
    endtask

    task automatic t_irq(input logic [3:0] l);
        int i;
        lat <= l;
        ack_en <= 1'b1;
        apb(1'b1, acr_pkg::OFS_INTCTRL, 32'h2);
        // level output follows the written field one edge later
        @(posedge core_clk);
        `CHK("level", 2'h2, irq_priority_level)
        conv(12'h0AA);
        `CHK("irq raised", 1'b1, irq_req)
        i = 0;
        while (irq_req !== 1'b0 && i < 20) begin
            @(posedge core_clk);
            i++;
        end
        `CHK("irq dropped", 1'b0, irq_req)
        if (i >= 20) begin
            end_sim();
        end
        apb(1'b0, acr_pkg::OFS_FLAG, 32'h0);
        `CHK("flag after dispatch", 32'h0, rd)
    endtask

    task automatic t_scan();
        logic [3:0] s [4] = '{4'h4, 4'h5, 4'h3, 4'h4};
        apb(1'b1, acr_pkg::OFS_MUX, 32'h18);
        conv(12'h001);
        @(posedge core_clk);
        `CHK("no scan", 4'h3, positive_input_select)
        apb(1'b1, acr_pkg::OFS_SCAN, 32'h02);
        @(posedge core_clk);
        `CHK("scan base", 4'h3, positive_input_select)
        for (int i = 0; i < 4; i++) begin
            conv(12'h001);
            @(posedge core_clk);
            `CHK("scan select", s[i], positive_input_select)
        end
        apb(1'b0, acr_pkg::OFS_SCAN, 32'h0);
        `CHK("scan offset", 32'h12, rd)
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        conv_done = 1'b0;
        conv_value = 12'h000;
        ack_en = 1'b0;
        lat = 4'h0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_flag();
        t_format();
        t_compare();
        t_irq(4'h0);
        t_irq(4'h3);
        t_scan();
        end_sim();
    end
endmodule
